// [include/sebs_defines.svh]
`ifndef SEBS_DEFINES_SVH
`define SEBS_DEFINES_SVH

// System clock rate
`define SEBS_CLK_MHZ 200

// Output hold after a serial clock fall, least time
`define SEBS_HOLD_NS 300
`define SEBS_HOLD_CYCLES ((`SEBS_HOLD_NS * `SEBS_CLK_MHZ + 999) / 1000)
`define SEBS_HOLD_W 7

// Self-timed write cycle, longest time
`define SEBS_TWR_US 5000
`define SEBS_TWR_CYCLES (`SEBS_TWR_US * `SEBS_CLK_MHZ)

// Array geometry
`define SEBS_ADDR_W 12
`define SEBS_PAGE_BYTES 32
`define SEBS_BYTE_W 8

// Device-type code, value arbitrary
`define SEBS_DEV_TYPE 4'h6

// Control byte fields
`define SEBS_CTRL_TYPE_HI 7
`define SEBS_CTRL_TYPE_LO 4
`define SEBS_CTRL_SEL_HI 3
`define SEBS_CTRL_SEL_LO 1
`define SEBS_CTRL_DIR 0

// Bit counter marks
`define SEBS_BIT_FIRST 4'h1
`define SEBS_BIT_ACK 4'h8
`define SEBS_BIT_POST 4'h9

`endif

// [include/sebs_pkg.sv]
package sebs_pkg;

   typedef enum logic [2:0] {
      st_idle,
      st_ctrl,
      st_addr_hi,
      st_addr_lo,
      st_wdata,
      st_read,
      st_ignore
   } sebs_state_t;

endpackage

// [rtl/sebs_sync.sv]
`timescale 1ns/100ps
module sebs_sync #(
   parameter int unsigned WIDTH = 1
) (
   // Clock and reset
   input wire logic i_sys_clk,
   input wire logic i_srst,
   // Levels
   input wire logic [WIDTH-1:0] i_async,
   output logic [WIDTH-1:0] o_sync
);

   logic [WIDTH-1:0] meta_q;

   // Idle bus lines are high, so reset to ones
   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         meta_q <= '1;
         o_sync <= '1;
      end else begin
         meta_q <= i_async;
         o_sync <= meta_q;
      end
   end

endmodule // sebs_sync

// [rtl/sebs_wr_timer.sv]
`timescale 1ns/100ps
module sebs_wr_timer #(
   parameter int unsigned CYCLES = 1000000
) (
   // Clock and reset
   input wire logic i_sys_clk,
   input wire logic i_srst,
   // Control
   input wire logic i_start,
   output logic o_busy
);

   localparam int unsigned CNT_W = $clog2(CYCLES + 1);

   logic [CNT_W-1:0] cnt_q;

   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         cnt_q <= '0;
         o_busy <= 1'b0;
      end else if (i_start) begin
         cnt_q <= CNT_W'(CYCLES);
         o_busy <= 1'b1;
      end else if (cnt_q != '0) begin
         cnt_q <= cnt_q - 1'b1;
         o_busy <= (cnt_q != CNT_W'(1));
      end
   end

endmodule // sebs_wr_timer

// [rtl/sebs_slave.sv]
`timescale 1ns/100ps
`include "sebs_defines.svh"
module sebs_slave
   import sebs_pkg::*;
#(
   parameter int unsigned ADDR_W = `SEBS_ADDR_W,
   parameter int unsigned PAGE_BYTES = `SEBS_PAGE_BYTES,
   parameter logic [3:0] DEV_TYPE = `SEBS_DEV_TYPE,
   parameter int unsigned TWR_CYCLES = `SEBS_TWR_CYCLES
) (
   // Clock and reset
   input wire logic i_sys_clk,
   input wire logic i_srst,
   // Two-wire bus pins
   input wire logic i_scl,
   input wire logic i_sda,
   output logic o_sda,
   output logic o_sda_oe,
   // Strap pins
   input wire logic i_select_bit_high,
   input wire logic i_select_bit_mid,
   input wire logic i_select_bit_low,
   input wire logic i_write_protect,
   // Array port
   output logic [ADDR_W-1:0] o_mem_addr,
   output logic o_mem_rd,
   input wire logic [`SEBS_BYTE_W-1:0] i_mem_rdata,
   output logic o_mem_wr,
   output logic [`SEBS_BYTE_W-1:0] o_mem_wdata,
   // Status
   output logic o_write_busy
);

   localparam int unsigned PAGE_W = $clog2(PAGE_BYTES);
   localparam int unsigned BW = `SEBS_BYTE_W;

   // Synchronised pins
   logic [5:0] pins_s;
   logic scl_s;
   logic sda_s;
   logic wp_s;
   logic [2:0] sel_s;

   // Line history and events
   logic scl_prev_q;
   logic sda_prev_q;
   logic scl_rise;
   logic scl_fall;
   logic start_ev;
   logic stop_ev;

   // Protocol state
   sebs_state_t state_q;
   logic [3:0] bit_cnt_q;
   logic [BW-1:0] rx_q;
   logic [BW-1:0] tx_q;
   logic [ADDR_W-1:0] ptr_q;
   logic dev_ack_q;
   logic oe_req_q;
   logic [`SEBS_HOLD_W-1:0] hold_cnt_q;

   // Page buffer and commit walk
   logic [BW-1:0] page_buf_q [PAGE_BYTES];
   logic [PAGE_BYTES-1:0] mask_q;
   logic commit_q;
   logic [PAGE_W-1:0] commit_idx_q;
   logic rd_ret_q;
   logic timer_busy;
   logic timer_start;

   // Decode wires
   logic rx_state;
   logic busy;
   logic ctrl_ok;
   logic ack_d;
   logic byte_end;
   logic ack_end;
   logic rd_ack_rise;
   logic fetch_first;
   logic fetch_next;
   logic tx_bit_fall;
   logic tx_rel_fall;
   logic commit_go;
   logic commit_last;
   logic [PAGE_W-1:0] wr_slot;

   function automatic logic ctrl_match(input logic [BW-1:0] b,
                                       input logic [2:0] sel);
      ctrl_match =
         (b[`SEBS_CTRL_TYPE_HI:`SEBS_CTRL_TYPE_LO] == DEV_TYPE) &&
         (b[`SEBS_CTRL_SEL_HI:`SEBS_CTRL_SEL_LO] == sel);
   endfunction

   sebs_sync #(
      .WIDTH(6)
   ) u_sync (
      .i_sys_clk(i_sys_clk),
      .i_srst(i_srst),
      .i_async({i_scl, i_sda, i_write_protect, i_select_bit_high,
                i_select_bit_mid, i_select_bit_low}),
      .o_sync(pins_s)
   );

   assign scl_s = pins_s[5];
   assign sda_s = pins_s[4];
   assign wp_s = pins_s[3];
   assign sel_s = pins_s[2:0];

   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         scl_prev_q <= 1'b1;
         sda_prev_q <= 1'b1;
      end else begin
         scl_prev_q <= scl_s;
         sda_prev_q <= sda_s;
      end
   end

   assign scl_rise = scl_s & ~scl_prev_q;
   assign scl_fall = ~scl_s & scl_prev_q;
   assign start_ev = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
   assign stop_ev = scl_s & scl_prev_q & ~sda_prev_q & sda_s;

   // Byte framing
   assign rx_state = (state_q == st_ctrl) || (state_q == st_addr_hi) ||
                     (state_q == st_addr_lo) || (state_q == st_wdata);
   assign byte_end = scl_fall && rx_state && (bit_cnt_q == `SEBS_BIT_ACK);
   assign ack_end = scl_fall && (bit_cnt_q == `SEBS_BIT_POST);

   assign busy = commit_q | timer_busy;
   // Busy device refuses even its own control byte
   assign ctrl_ok = ctrl_match(rx_q, sel_s) && !busy;
   assign ack_d = (state_q == st_ctrl) ? ctrl_ok : 1'b1;

   // Read side
   assign rd_ack_rise = scl_rise && (state_q == st_read) &&
                        (bit_cnt_q == `SEBS_BIT_ACK) && !dev_ack_q;
   assign fetch_first = byte_end && (state_q == st_ctrl) && ctrl_ok &&
                        rx_q[`SEBS_CTRL_DIR];
   assign fetch_next = rd_ack_rise && !sda_s;
   assign tx_bit_fall = scl_fall && (state_q == st_read) &&
                        (bit_cnt_q >= `SEBS_BIT_FIRST) &&
                        (bit_cnt_q < `SEBS_BIT_ACK);
   assign tx_rel_fall = scl_fall && (state_q == st_read) &&
                        (bit_cnt_q == `SEBS_BIT_ACK);

   // Write side
   assign wr_slot = ptr_q[PAGE_W-1:0];
   assign commit_go = stop_ev && (state_q == st_wdata) &&
                      (mask_q != '0) && !wp_s;
   assign commit_last = commit_q && (commit_idx_q == PAGE_W'(PAGE_BYTES - 1));
   assign timer_start = commit_last;

   // Protocol state machine
   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         state_q <= st_idle;
      end else if (start_ev) begin
         state_q <= st_ctrl;
      end else if (stop_ev) begin
         state_q <= st_idle;
      end else if (byte_end) begin
         case (state_q)
            st_ctrl: begin
               if (!ctrl_ok)
                  state_q <= st_ignore;
               else if (rx_q[`SEBS_CTRL_DIR])
                  state_q <= st_read;
               else
                  state_q <= st_addr_hi;
            end
            st_addr_hi: begin
               state_q <= st_addr_lo;
            end
            st_addr_lo: begin
               state_q <= st_wdata;
            end
            default: begin
               state_q <= state_q;
            end
         endcase
      end else if (rd_ack_rise && sda_s) begin
         state_q <= st_ignore;
      end
   end

   // Bit counter: 0..7 data, 8 waits ack pulse, 9 inside ack pulse
   always_ff @(posedge i_sys_clk) begin
      if (i_srst || start_ev || stop_ev)
         bit_cnt_q <= '0;
      else if (ack_end)
         bit_cnt_q <= '0;
      else if (scl_rise && bit_cnt_q < `SEBS_BIT_POST)
         bit_cnt_q <= bit_cnt_q + 1'b1;
   end

   // Receive shift, sampled while clock is high
   always_ff @(posedge i_sys_clk) begin
      if (i_srst)
         rx_q <= '0;
      else if (scl_rise && bit_cnt_q < `SEBS_BIT_ACK)
         rx_q <= {rx_q[BW-2:0], sda_s};
   end

   // Transmit shift and array data capture
   always_ff @(posedge i_sys_clk) begin
      if (i_srst)
         tx_q <= '0;
      else if (rd_ret_q)
         tx_q <= i_mem_rdata;
      else if (scl_rise && state_q == st_read && bit_cnt_q < `SEBS_BIT_ACK)
         tx_q <= {tx_q[BW-2:0], 1'b0};
   end

   // Address pointer
   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         ptr_q <= '0;
      end else if (byte_end && state_q == st_addr_hi) begin
         ptr_q[ADDR_W-1:BW] <= rx_q[ADDR_W-BW-1:0];
      end else if (byte_end && state_q == st_addr_lo) begin
         ptr_q[BW-1:0] <= rx_q;
      end else if (byte_end && state_q == st_wdata) begin
         ptr_q[PAGE_W-1:0] <= wr_slot + 1'b1;
      end else if (rd_ack_rise) begin
         ptr_q <= ptr_q + 1'b1;
      end
   end

   // Own acknowledge flag, kept apart from the master's
   always_ff @(posedge i_sys_clk) begin
      if (i_srst || start_ev || stop_ev)
         dev_ack_q <= 1'b0;
      else if (byte_end)
         dev_ack_q <= ack_d;
      else if (ack_end)
         dev_ack_q <= 1'b0;
   end

   // Requested data line drive, set only on clock falls
   always_ff @(posedge i_sys_clk) begin
      if (i_srst || start_ev || stop_ev)
         oe_req_q <= 1'b0;
      else if (byte_end)
         oe_req_q <= ack_d;
      else if (ack_end)
         oe_req_q <= (state_q == st_read) && !tx_q[BW-1];
      else if (tx_bit_fall)
         oe_req_q <= !tx_q[BW-1];
      else if (tx_rel_fall)
         oe_req_q <= 1'b0;
   end

   // Drive change waits out the hold time after the clock fall
   always_ff @(posedge i_sys_clk) begin
      if (i_srst || start_ev || stop_ev) begin
         hold_cnt_q <= '0;
         o_sda_oe <= 1'b0;
      end else if (scl_fall) begin
         hold_cnt_q <= `SEBS_HOLD_W'(`SEBS_HOLD_CYCLES);
      end else if (hold_cnt_q != '0) begin
         hold_cnt_q <= hold_cnt_q - 1'b1;
         if (hold_cnt_q == `SEBS_HOLD_W'(1))
            o_sda_oe <= oe_req_q;
      end
   end

   // Open-drain: only ever pulls low
   always_ff @(posedge i_sys_clk) begin
      o_sda <= 1'b0;
   end

   // Page buffer fill; overflow overwrites within the page
   always_ff @(posedge i_sys_clk) begin
      if (byte_end && state_q == st_wdata)
         page_buf_q[wr_slot] <= rx_q;
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_srst)
         mask_q <= '0;
      else if (byte_end && state_q == st_addr_lo)
         mask_q <= '0;
      else if (byte_end && state_q == st_wdata)
         mask_q[wr_slot] <= 1'b1;
   end

   // Commit walk over the page, one slot per cycle
   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         commit_q <= 1'b0;
         commit_idx_q <= '0;
      end else if (commit_go) begin
         commit_q <= 1'b1;
         commit_idx_q <= '0;
      end else if (commit_q) begin
         commit_idx_q <= commit_idx_q + 1'b1;
         if (commit_last)
            commit_q <= 1'b0;
      end
   end

   sebs_wr_timer #(
      .CYCLES(TWR_CYCLES)
   ) u_wr_timer (
      .i_sys_clk(i_sys_clk),
      .i_srst(i_srst),
      .i_start(timer_start),
      .o_busy(timer_busy)
   );

   // Array port; reads cannot overlap a commit since busy refuses them
   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         o_mem_addr <= '0;
         o_mem_rd <= 1'b0;
         o_mem_wr <= 1'b0;
         o_mem_wdata <= '0;
         rd_ret_q <= 1'b0;
      end else begin
         o_mem_rd <= fetch_first | fetch_next;
         o_mem_wr <= commit_q && mask_q[commit_idx_q];
         o_mem_wdata <= mask_q[commit_idx_q] ? page_buf_q[commit_idx_q] : '0;
         rd_ret_q <= o_mem_rd;
         if (commit_q)
            o_mem_addr <= {ptr_q[ADDR_W-1:PAGE_W], commit_idx_q};
         else if (fetch_next)
            o_mem_addr <= ptr_q + 1'b1;
         else if (fetch_first)
            o_mem_addr <= ptr_q;
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_srst)
         o_write_busy <= 1'b0;
      else
         o_write_busy <= busy | commit_go;
   end

endmodule // sebs_slave

// [tb/sebs_slave_checker.sv]
`timescale 1ns/100ps
module sebs_slave_checker #(
   parameter int unsigned ADDR_W = 12,
   parameter int unsigned TWR_CYCLES = 200
) (
   // Clock and reset
   input wire logic i_sys_clk,
   input wire logic i_srst,
   // Pins
   input wire logic i_scl,
   input wire logic i_write_protect,
   input wire logic o_sda,
   input wire logic o_sda_oe,
   // Array and status
   input wire logic [ADDR_W-1:0] o_mem_addr,
   input wire logic o_mem_rd,
   input wire logic o_mem_wr,
   input wire logic o_write_busy
);
   logic [ADDR_W-6:0] page_q;
   logic [31:0] busy_cnt_q;
   default clocking cb @(posedge i_sys_clk);
   endclocking
   default disable iff (i_srst);
   always_ff @(posedge i_sys_clk) begin
      page_q <= o_mem_addr[ADDR_W-1:5];
      busy_cnt_q <= (i_srst || !o_write_busy) ? 32'h0 : busy_cnt_q + 32'h1;
   end
   hold_delay_a: assert property (
      $changed(o_sda_oe) |-> $past(i_scl, 55) == 1'b0)
      else $error("data drive moved too soon after clock fall");
   drive_low_a: assert property (o_sda_oe |-> o_sda == 1'b0)
      else $error("data drive not low");
   busy_quiet_a: assert property (
      o_write_busy |-> !o_sda_oe)
      else $error("data driven while write busy");
   wr_in_busy_a: assert property (o_mem_wr |-> o_write_busy)
      else $error("array write outside write cycle");
   wp_block_a: assert property (i_write_protect |-> !o_mem_wr)
      else $error("array write while protected");
   page_keep_a: assert property (
      o_mem_wr && $past(o_mem_wr) |-> o_mem_addr[ADDR_W-1:5] == page_q)
      else $error("page write left its page");
   rd_pulse_a: assert property (
      o_mem_rd |-> !o_write_busy ##1 !o_mem_rd)
      else $error("bad array read pulse");
   busy_end_a: assert property (busy_cnt_q < TWR_CYCLES + 64)
      else $error("write cycle too long");
   busy_len_a: assert property (
      $fell(o_write_busy) |-> busy_cnt_q >= TWR_CYCLES)
      else $error("write cycle too short");
   cover property ($rose(o_write_busy));
   cover property (o_mem_rd);
   cover property ($rose(o_sda_oe));
endmodule // sebs_slave_checker

bind sebs_slave sebs_slave_checker #(
   .ADDR_W(ADDR_W),
   .TWR_CYCLES(TWR_CYCLES)
) u_chk (
   .i_sys_clk(i_sys_clk), .i_srst(i_srst), .i_scl(i_scl),
   .i_write_protect(i_write_protect), .o_sda(o_sda), .o_sda_oe(o_sda_oe),
   .o_mem_addr(o_mem_addr), .o_mem_rd(o_mem_rd), .o_mem_wr(o_mem_wr),
   .o_write_busy(o_write_busy));

// [tb/sebs_master.sv]
`timescale 1ns/100ps
module sebs_master #(
   parameter int unsigned HALF = 72
) (
   // Clock
   input wire logic i_sys_clk,
   // Bus lines
   input wire logic i_sda,
   output logic o_scl,
   output logic o_sda_pull
);
   initial begin
      o_scl = 1'b1;
      o_sda_pull = 1'b0;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge i_sys_clk);
   endtask
   task automatic put_bit(input logic b, output logic r);
      tick(20);
      o_sda_pull <= !b;
      tick(HALF - 20);
      o_scl <= 1'b1;
      tick(HALF / 2);
      r = i_sda;
      tick(HALF / 2);
      o_scl <= 1'b0;
   endtask
   task automatic start_cond();
      tick(20);
      o_sda_pull <= 1'b0;
      tick(HALF);
      o_scl <= 1'b1;
      tick(HALF);
      o_sda_pull <= 1'b1;
      tick(HALF);
      o_scl <= 1'b0;
   endtask
   task automatic stop_cond();
      tick(20);
      o_sda_pull <= 1'b1;
      tick(HALF);
      o_scl <= 1'b1;
      tick(HALF);
      o_sda_pull <= 1'b0;
      tick(HALF);
   endtask
   // Ninth clock carries the acknowledge; last is 1 to withhold it
   task automatic xfer(input logic [7:0] d, input logic last,
                       output logic [7:0] r, output logic ack);
      logic a;
      for (int i = 7; i >= 0; i--) begin
         put_bit(d[i], r[i]);
      end
      put_bit(last, a);
      ack = !a;
   endtask
endmodule // sebs_master

// [tb/sebs_slave_bench.sv]
`timescale 1ns/100ps
`include "sebs_defines.svh"
`define CHECK(got, exp) begin \
   samples_checked++; \
   if ((got) !== (exp)) begin \
      fail_count++; \
      $display("[FAIL] %0t got %h want %h", $time, got, exp); \
   end \
end
module sebs_slave_bench;
   typedef struct packed {logic [2:0] s; logic [7:0] c; logic a;} sebs_row_t;
   localparam logic [3:0] DT = `SEBS_DEV_TYPE;
   logic i_sys_clk = 1'b0;
   logic i_srst = 1'b1;
   logic [2:0] straps = 3'h5;
   logic wp = 1'b0;
   logic [7:0] rdata = 8'h00;
   logic [7:0] mem [4096];
   logic scl, pull, sda_o, sda_oe, mem_rd, mem_wr, busy, ack;
   logic [11:0] mem_addr;
   logic [7:0] mem_wdata, rd;
   wire sda_w = !pull && !(sda_oe && !sda_o);
   wire [24:0] idle_outs = {sda_o, sda_oe, mem_rd, mem_wr, busy, mem_addr,
                            mem_wdata};
   int fail_count = 0;
   int samples_checked = 0;
   sebs_row_t rows [4] = '{
      '{3'h5, {DT, 3'h5, 1'b0}, 1'b1},
      '{3'h2, {DT, 3'h2, 1'b0}, 1'b1},
      '{3'h5, {DT, 3'h4, 1'b0}, 1'b0},
      '{3'h5, {~DT, 3'h5, 1'b0}, 1'b0}};
   function automatic logic [7:0] pat(input logic [11:0] a);
      return a[7:0] + {a[11:8], 4'h3};
   endfunction
   initial begin
      forever #2.5 i_sys_clk = ~i_sys_clk;
   end
   // Array with one cycle of read latency
   always @(posedge i_sys_clk) begin
      if (mem_rd) rdata <= mem[mem_addr];
      if (mem_wr) mem[mem_addr] <= mem_wdata;
   end
   sebs_slave #(.TWR_CYCLES(2800)) u_dut (
      .i_sys_clk(i_sys_clk), .i_srst(i_srst), .i_scl(scl), .i_sda(sda_w),
      .o_sda(sda_o), .o_sda_oe(sda_oe), .i_select_bit_high(straps[2]),
      .i_select_bit_mid(straps[1]), .i_select_bit_low(straps[0]),
      .i_write_protect(wp), .o_mem_addr(mem_addr), .o_mem_rd(mem_rd),
      .i_mem_rdata(rdata), .o_mem_wr(mem_wr), .o_mem_wdata(mem_wdata),
      .o_write_busy(busy));
   sebs_master u_mst (
      .i_sys_clk(i_sys_clk), .i_sda(sda_w), .o_scl(scl), .o_sda_pull(pull));
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic send(input logic [7:0] d);
      u_mst.xfer(d, 1'b1, rd, ack);
   endtask
   task automatic addr_set(input logic [11:0] a);
      u_mst.start_cond();
      send({DT, 3'h5, 1'b0});
      send({4'h0, a[11:8]});
      send(a[7:0]);
      `CHECK(ack, 1'b1)
   endtask
   task automatic wait_idle();
      int n;
      n = 0;
      while (busy !== 1'b0 && n < 4000) begin
         @(posedge i_sys_clk);
         n++;
      end
      if (n >= 4000) begin
         $display("[FAIL] %0t write cycle never ended", $time);
         fail_count++;
         end_of_test();
      end
   endtask
   initial begin
      for (int i = 0; i < 4096; i++) begin
         mem[i] = pat(i[11:0]);
      end
      repeat (16) @(posedge i_sys_clk);
      i_srst <= 1'b0;
      @(posedge i_sys_clk);
      #1;
      `CHECK(idle_outs, 25'h0)
      @(posedge i_sys_clk);
      foreach (rows[k]) begin
         straps <= rows[k].s;
         u_mst.start_cond();
         send(rows[k].c);
         `CHECK(ack, rows[k].a)
         send(8'h00);
         `CHECK(ack, rows[k].a)
         u_mst.stop_cond();
      end
      straps <= 3'h5;
      addr_set(12'h123);
      send(8'ha5);
      `CHECK(ack, 1'b1)
      for (int p = 0; p < 2; p++) begin
         u_mst.stop_cond();
         u_mst.start_cond();
         send({DT, 3'h5, 1'b0});
         `CHECK(ack, p[0])
      end
      u_mst.stop_cond();
      `CHECK(mem[12'h123], 8'ha5)
      wp <= 1'b1;
      addr_set(12'h124);
      send(8'h3c);
      `CHECK(ack, 1'b1)
      u_mst.stop_cond();
      u_mst.tick(40);
      `CHECK({busy, mem[12'h124]}, {1'b0, pat(12'h124)})
      wp <= 1'b0;
      addr_set(12'h2e0);
      for (int k = 0; k < 33; k++) begin
         send(8'h40 + k[7:0]);
         `CHECK(ack, 1'b1)
      end
      u_mst.stop_cond();
      wait_idle();
      `CHECK(mem[12'h2e0], 8'h60)
      `CHECK(mem[12'h2e1], 8'h41)
      `CHECK(mem[12'h2ff], 8'h5f)
      `CHECK(mem[12'h300], pat(12'h300))
      u_mst.start_cond();
      send({DT, 3'h5, 1'b1});
      `CHECK(ack, 1'b1)
      u_mst.xfer(8'hff, 1'b1, rd, ack);
      `CHECK(rd, 8'h41)
      u_mst.stop_cond();
      addr_set(12'hfff);
      u_mst.start_cond();
      send({DT, 3'h5, 1'b1});
      u_mst.xfer(8'hff, 1'b0, rd, ack);
      `CHECK(rd, pat(12'hfff))
      u_mst.xfer(8'hff, 1'b1, rd, ack);
      `CHECK(rd, pat(12'h000))
      u_mst.stop_cond();
      `CHECK({busy, mem[12'hfff]}, {1'b0, pat(12'hfff)})
      // Reset in mid-run, inside a write cycle
      addr_set(12'h050);
      send(8'h77);
      `CHECK(ack, 1'b1)
      u_mst.stop_cond();
      i_srst <= 1'b1;
      repeat (4) @(posedge i_sys_clk);
      i_srst <= 1'b0;
      @(posedge i_sys_clk);
      #1;
      `CHECK(idle_outs, 25'h0)
      @(posedge i_sys_clk);
      u_mst.start_cond();
      send({DT, 3'h5, 1'b1});
      `CHECK(ack, 1'b1)
      u_mst.xfer(8'hff, 1'b1, rd, ack);
      `CHECK(rd, pat(12'h000))
      u_mst.stop_cond();
      end_of_test();
   end
endmodule // sebs_slave_bench
